// *** shared/nvac_consts.svh ***
`ifndef NVAC_CONSTS_SVH
`define NVAC_CONSTS_SVH
// register byte offsets
`define NVAC_OFF_CTRL      8'h00
`define NVAC_OFF_UNLOCK    8'h04
`define NVAC_OFF_ADDR_LO   8'h08
`define NVAC_OFF_ADDR_HI   8'h0C
`define NVAC_OFF_DATA_LO   8'h10
`define NVAC_OFF_DATA_HI   8'h14
`define NVAC_OFF_STATUS    8'h18
// control register bit positions
`define NVAC_BIT_RD        0
`define NVAC_BIT_WR        1
`define NVAC_BIT_PERMIT    2
`define NVAC_BIT_ABORT     3
`define NVAC_BIT_PGD       7
// status register bit positions
`define NVAC_BIT_DONE      0
`define NVAC_BIT_BUSY      1
`define NVAC_BIT_PROT      2
// unlock keys
`define NVAC_KEY1          8'h55
`define NVAC_KEY2          8'hAA
// reset values
`define NVAC_RST_BYTE      8'h00
// write time
`define NVAC_WRITE_TIME_NS 5000000
`define NVAC_CLK_NS        40
`define NVAC_WRITE_CYCLES  ((`NVAC_WRITE_TIME_NS + `NVAC_CLK_NS - 1) / `NVAC_CLK_NS)
// unlock window, in bus writes
`define NVAC_UNLOCK_WIN    3
`endif

// *** shared/nvac_pkg.sv ***
package nvac_pkg;
    typedef enum logic [1:0] {
        NVAC_IDLE,
        NVAC_READ,
        NVAC_WRITE
    } nvac_state_e;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } nvac_req_s;

    typedef struct packed {
        logic        pgd;
        logic        write_abort_flag;
        logic        write_permit;
        logic        wr;
        logic        rd;
    } nvac_ctrl_s;
endpackage

// *** verilog/nvac_write_timer.sv ***
`timescale 1ns/10ps
`include "nvac_consts.svh"
module nvac_write_timer import nvac_pkg::*; #(
    parameter int CYCLES = `NVAC_WRITE_CYCLES
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    logic [31:0] cnt_ff;
    logic        busy_ff;
    logic        done_ff;

    // self-timed write duration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff  <= 32'h0000_0000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                cnt_ff  <= 32'(CYCLES - 1);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (cnt_ff == 32'h0000_0000) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 32'h0000_0001;
                end
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
endmodule // nvac_write_timer

// *** verilog/nvac_memories.sv ***
`timescale 1ns/10ps
module nvac_memories import nvac_pkg::*; #(
    parameter int DATA_DEPTH = 256,
    parameter int PROG_DEPTH = 4096
) (
    // clock
    input  wire logic        hclk,
    // data memory port
    input  wire logic        ee_we,
    input  wire logic [7:0]  ee_addr,
    input  wire logic [7:0]  ee_wdata,
    output logic      [7:0]  ee_rdata,
    // program memory read port
    input  wire logic [11:0] pm_addr,
    output logic      [13:0] pm_rdata,
    // programmer port
    input  wire logic        pgm_we,
    input  wire logic [11:0] pgm_addr,
    input  wire logic [13:0] pgm_wdata
);
    logic [7:0]  ee_mem [DATA_DEPTH];
    logic [13:0] pm_mem [PROG_DEPTH];

    // byte write replaces the whole location, erase then program
    always_ff @(posedge hclk) begin
        if (ee_we) begin
            ee_mem[ee_addr] <= ee_wdata;
        end
    end

    always_ff @(posedge hclk) begin
        if (pgm_we) begin
            pm_mem[pgm_addr] <= pgm_wdata;
        end
    end

    assign ee_rdata = ee_mem[ee_addr];
    assign pm_rdata = pm_mem[pm_addr];
endmodule // nvac_memories

// *** verilog/nvac_top.sv ***
`timescale 1ns/10ps
`include "nvac_consts.svh"
// Function
// - 256-byte data memory, 8-bit data register
// - join data and address register pairs
// - 4K-word program memory, addresses 0 to 0FFF
// - one-word program reads, no processor program writes
// - data byte write replaces the location
// - write duration timed by internal timer
// - protection leaves processor access intact
// - protection blocks external programmer access
// - select bit picks memory, reset clears
// - start bits set-only, hardware clears
// - writes need permit bit, cleared at power-up
// - external or watchdog reset sets abort flag
// - data and address survive aborting reset
// - done flag set by hardware, software clears
// - unlock port stores nothing, reads zero
// - unimplemented bits read as zero
module nvac_top import nvac_pkg::*; #(
    parameter int WRITE_CYCLES = `NVAC_WRITE_CYCLES
) (
    // clock and resets
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        por_n,
    input  wire logic        external_reset_pin_ev,
    input  wire logic        watchdog_timer_ev,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // code protection and programmer
    input  wire logic        code_protect,
    input  wire logic        pgm_req,
    input  wire logic        pgm_write,
    input  wire logic [11:0] pgm_addr,
    input  wire logic [13:0] pgm_wdata,
    output logic      [13:0] pgm_rdata,
    output logic             pgm_refused,
    // status out
    output logic             write_done_flag,
    output logic             write_busy
);
    nvac_req_s   req_ff;
    nvac_ctrl_s  ctrl;
    logic        pgd_ff;
    logic        rd_ff;
    logic        wr_ff;
    logic        permit_ff;
    logic        abort_ff;
    nvac_state_e state_ff;
    logic [7:0]  addr_lo_ff;
    logic [3:0]  addr_hi_ff;
    logic [7:0]  data_lo_ff;
    logic [5:0]  data_hi_ff;
    logic        done_flag_ff;
    logic [1:0]  key_ff;
    logic        ext_pend_ff;
    logic [13:0] pgm_rdata_ff;
    logic        pgm_ref_ff;
    logic        wr_pend_ff;
    logic        pwr_on_ff;
    logic [7:0]  ee_rdata;
    logic [13:0] pm_rdata;
    logic        tmr_busy;
    logic        tmr_done;
    logic        ee_we;
    logic        bus_wr;
    logic        wr_start;
    logic        pgm_ok;
    logic [31:0] rd_mux;
    logic [11:0] prog_addr;

    function automatic logic hit(input nvac_req_s r, input logic [7:0] off);
        hit = r.sel && (r.addr == off);
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus_wr    = req_ff.sel && req_ff.write;
    // control bits live in two reset domains, joined for readback
    assign ctrl      = '{pgd: pgd_ff, write_abort_flag: abort_ff, write_permit: permit_ff, wr: wr_ff, rd: rd_ff};

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_ff <= '0;
        end else if (hready) begin
            req_ff.sel   <= hsel && htrans[1];
            req_ff.write <= hwrite;
            req_ff.addr  <= haddr[7:0];
            req_ff.wdata <= 32'h0000_0000;
        end
    end

    // power-on only: permit clears here, not on other resets
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            pwr_on_ff <= 1'b1;
        end else begin
            pwr_on_ff <= 1'b0;
        end
    end

    // address and data survive a write-aborting reset
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            addr_lo_ff <= `NVAC_RST_BYTE;
            addr_hi_ff <= 4'h0;
        end else if (bus_wr && hit(req_ff, `NVAC_OFF_ADDR_LO)) begin
            addr_lo_ff <= hwdata[7:0];
        end else if (bus_wr && hit(req_ff, `NVAC_OFF_ADDR_HI)) begin
            addr_hi_ff <= hwdata[3:0];
        end
    end

    assign prog_addr = {addr_hi_ff, addr_lo_ff};

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            data_lo_ff <= `NVAC_RST_BYTE;
            data_hi_ff <= 6'h00;
        end else if (state_ff == NVAC_READ) begin
            if (pgd_ff) begin
                data_lo_ff <= pm_rdata[7:0];
                data_hi_ff <= pm_rdata[13:8];
            end else begin
                data_lo_ff <= ee_rdata;
            end
        end else if (bus_wr && hit(req_ff, `NVAC_OFF_DATA_LO)) begin
            data_lo_ff <= hwdata[7:0];
        end else if (bus_wr && hit(req_ff, `NVAC_OFF_DATA_HI)) begin
            data_hi_ff <= hwdata[5:0];
        end
    end

    // unlock key pair; only the two most recent writes count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_ff <= 2'b00;
        end else if (bus_wr) begin
            if (hit(req_ff, `NVAC_OFF_UNLOCK) && hwdata[7:0] == `NVAC_KEY1) begin
                key_ff <= 2'b01;
            end else if (hit(req_ff, `NVAC_OFF_UNLOCK) && hwdata[7:0] == `NVAC_KEY2
                         && key_ff == 2'b01) begin
                key_ff <= 2'b11;
            end else begin
                key_ff <= 2'b00;
            end
        end
    end

    assign wr_start = bus_wr && hit(req_ff, `NVAC_OFF_CTRL) && hwdata[`NVAC_BIT_WR]
                      && key_ff == 2'b11 && permit_ff
                      && hwdata[`NVAC_BIT_PERMIT] && !pgd_ff
                      && !hwdata[`NVAC_BIT_PGD] && state_ff == NVAC_IDLE;

    // control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgd_ff <= 1'b0;
            rd_ff  <= 1'b0;
            wr_ff  <= 1'b0;
        end else begin
            if (bus_wr && hit(req_ff, `NVAC_OFF_CTRL) && state_ff == NVAC_IDLE) begin
                pgd_ff <= hwdata[`NVAC_BIT_PGD];
                if (hwdata[`NVAC_BIT_RD] && !hwdata[`NVAC_BIT_WR]) begin
                    rd_ff <= 1'b1;
                end
            end
            if (wr_start) begin
                wr_ff <= 1'b1;
            end else if (tmr_done) begin
                wr_ff <= 1'b0;
            end
            if (state_ff == NVAC_READ) begin
                rd_ff <= 1'b0;
            end
        end
    end

    // permit survives non-power resets
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            permit_ff <= 1'b0;
        end else if (pwr_on_ff) begin
            permit_ff <= 1'b0;
        end else if (bus_wr && hit(req_ff, `NVAC_OFF_CTRL)) begin
            permit_ff <= hwdata[`NVAC_BIT_PERMIT];
        end
    end

    // abort flag: a write pending when hresetn asserts
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            wr_pend_ff <= 1'b0;
        end else begin
            wr_pend_ff <= hresetn && wr_ff;
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            ext_pend_ff <= 1'b0;
        end else begin
            ext_pend_ff <= (external_reset_pin_ev || watchdog_timer_ev) && wr_ff;
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            abort_ff <= 1'b0;
        end else begin
            if (ext_pend_ff || (wr_pend_ff && !hresetn)) begin
                abort_ff <= 1'b1;
            end else if (bus_wr && hit(req_ff, `NVAC_OFF_CTRL)) begin
                abort_ff <= hwdata[`NVAC_BIT_ABORT];
            end
        end
    end

    // access sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= NVAC_IDLE;
        end else begin
            case (state_ff)
                NVAC_IDLE: begin
                    if (wr_start) begin
                        state_ff <= NVAC_WRITE;
                    end else if (bus_wr && hit(req_ff, `NVAC_OFF_CTRL)
                                 && hwdata[`NVAC_BIT_RD] && !hwdata[`NVAC_BIT_WR]) begin
                        state_ff <= NVAC_READ;
                    end
                end
                NVAC_READ: begin
                    state_ff <= NVAC_IDLE;
                end
                NVAC_WRITE: begin
                    if (tmr_done) begin
                        state_ff <= NVAC_IDLE;
                    end
                end
                default: begin
                    state_ff <= NVAC_IDLE;
                end
            endcase
        end
    end

    assign ee_we = tmr_done && state_ff == NVAC_WRITE;

    // done flag, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag_ff <= 1'b0;
        end else if (ee_we) begin
            done_flag_ff <= 1'b1;
        end else if (bus_wr && hit(req_ff, `NVAC_OFF_STATUS)
                     && !hwdata[`NVAC_BIT_DONE]) begin
            done_flag_ff <= 1'b0;
        end
    end

    // external programmer path
    assign pgm_ok = pgm_req && !code_protect;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgm_rdata_ff <= 14'h0000;
            pgm_ref_ff   <= 1'b0;
        end else begin
            pgm_ref_ff   <= pgm_req && code_protect;
            pgm_rdata_ff <= pgm_ok ? pm_rdata : 14'h0000;
        end
    end

    // processor read mux; protection not consulted here
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(req_ff, `NVAC_OFF_CTRL)) begin
            rd_mux[`NVAC_BIT_PGD]    = ctrl.pgd;
            rd_mux[`NVAC_BIT_ABORT]  = ctrl.write_abort_flag;
            rd_mux[`NVAC_BIT_PERMIT] = ctrl.write_permit;
            rd_mux[`NVAC_BIT_WR]     = ctrl.wr;
            rd_mux[`NVAC_BIT_RD]     = ctrl.rd;
        end else if (hit(req_ff, `NVAC_OFF_ADDR_LO)) begin
            rd_mux[7:0] = addr_lo_ff;
        end else if (hit(req_ff, `NVAC_OFF_ADDR_HI)) begin
            rd_mux[3:0] = addr_hi_ff;
        end else if (hit(req_ff, `NVAC_OFF_DATA_LO)) begin
            rd_mux[7:0] = data_lo_ff;
        end else if (hit(req_ff, `NVAC_OFF_DATA_HI)) begin
            rd_mux[5:0] = data_hi_ff;
        end else if (hit(req_ff, `NVAC_OFF_STATUS)) begin
            rd_mux[`NVAC_BIT_DONE] = done_flag_ff;
            rd_mux[`NVAC_BIT_BUSY] = tmr_busy;
            rd_mux[`NVAC_BIT_PROT] = code_protect;
        end
    end

    // unlock port and unmapped addresses fall through as zero
    assign hrdata          = rd_mux;
    assign pgm_rdata       = pgm_rdata_ff;
    assign pgm_refused     = pgm_ref_ff;
    assign write_done_flag = done_flag_ff;
    assign write_busy      = ctrl.wr;

    nvac_write_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (wr_start),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    nvac_memories u_mem (
        .hclk      (hclk),
        .ee_we     (ee_we),
        .ee_addr   (addr_lo_ff),
        .ee_wdata  (data_lo_ff),
        .ee_rdata  (ee_rdata),
        .pm_addr   (pgm_ok ? pgm_addr : prog_addr),
        .pm_rdata  (pm_rdata),
        .pgm_we    (pgm_ok && pgm_write),
        .pgm_addr  (pgm_addr),
        .pgm_wdata (pgm_wdata)
    );
endmodule // nvac_top

// *** tb/nvac_top_props.sv ***
`timescale 1ns/10ps
`include "nvac_consts.svh"
module nvac_top_props import nvac_pkg::*; #(
    parameter int WRITE_CYCLES = 20
) (
    // clock, resets and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        por_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // programmer and status
    input wire logic        code_protect,
    input wire logic        pgm_req,
    input wire logic        pgm_refused,
    input wire logic        write_done_flag,
    input wire logic        write_busy
);
    logic       dp_rd_ff;
    logic       dp_wr_ff;
    logic [7:0] dp_off_ff;
    int         busy_cnt_ff;

    // data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_rd_ff  <= 1'b0;
            dp_wr_ff  <= 1'b0;
            dp_off_ff <= 8'h00;
        end else if (hready) begin
            dp_rd_ff  <= hsel && htrans[1] && !hwrite;
            dp_wr_ff  <= hsel && htrans[1] && hwrite;
            dp_off_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_cnt_ff <= 0;
        end else if (write_busy) begin
            busy_cnt_ff <= busy_cnt_ff + 1;
        end else begin
            busy_cnt_ff <= 0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !por_n);

    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    a_unlock_zero: assert property (dp_rd_ff && dp_off_ff == `NVAC_OFF_UNLOCK |-> hrdata == 32'h0000_0000)
        else $error("unlock port read not zero");
    a_addr_hi_bits: assert property (dp_rd_ff && dp_off_ff == `NVAC_OFF_ADDR_HI |-> hrdata[31:4] == 28'h000_0000)
        else $error("high address spare bits set");
    a_data_hi_bits: assert property (dp_rd_ff && dp_off_ff == `NVAC_OFF_DATA_HI |-> hrdata[31:6] == 26'h000_0000)
        else $error("high data spare bits set");
    a_prog_refused: assert property (pgm_req && code_protect |=> pgm_refused)
        else $error("protected programmer access not refused");
    a_prog_allowed: assert property (pgm_req && !code_protect |=> !pgm_refused)
        else $error("open programmer access refused");
    a_done_holds: assert property (write_done_flag && !(dp_wr_ff && dp_off_ff == `NVAC_OFF_STATUS) |=> write_done_flag)
        else $error("done flag cleared without software");
    a_done_on_end: assert property ($fell(write_busy) |-> ##[0:1] write_done_flag)
        else $error("done flag missing after write");
    a_busy_min: assert property ($fell(write_busy) |-> busy_cnt_ff >= WRITE_CYCLES)
        else $error("write ended early");
    a_busy_cap: assert property (busy_cnt_ff <= WRITE_CYCLES + 2)
        else $error("write ran too long");
    a_start_holds: assert property (write_busy && busy_cnt_ff < WRITE_CYCLES |=> write_busy)
        else $error("write start bit cleared early");
endmodule // nvac_top_props

bind nvac_top nvac_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .code_protect(code_protect), .pgm_req(pgm_req), .pgm_refused(pgm_refused),
    .write_done_flag(write_done_flag), .write_busy(write_busy)
);

// *** tb/nvac_top_tb.sv ***
`timescale 1ns/10ps
`include "nvac_consts.svh"
module nvac_top_tb import nvac_pkg::*;;
    localparam int WC = 20;
    logic hclk, hresetn, por_n, ext_ev, wdt_ev, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic code_protect, pgm_req, pgm_write, pgm_refused, write_done_flag, write_busy, pr;
    logic [11:0] pgm_addr;
    logic [13:0] pgm_wdata, pgm_rdata, pw;
    int n_fail, checked;
    logic [7:0] offs [8];

    nvac_top #(.WRITE_CYCLES(WC)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .external_reset_pin_ev(ext_ev),
        .watchdog_timer_ev(wdt_ev), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .code_protect(code_protect), .pgm_req(pgm_req), .pgm_write(pgm_write),
        .pgm_addr(pgm_addr), .pgm_wdata(pgm_wdata), .pgm_rdata(pgm_rdata), .pgm_refused(pgm_refused),
        .write_done_flag(write_done_flag), .write_busy(write_busy)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        results;
    end

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(bit wr, logic [7:0] off, logic [31:0] d);
        hsel <= 1'b1;
        haddr <= 32'(off);
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask

    task automatic wr(logic [7:0] off, logic [31:0] d);
        bus(1'b1, off, d);
    endtask

    task automatic rdc(string name, logic [7:0] off, logic [31:0] exp);
        bus(1'b0, off, 32'h0000_0000);
        chk(name, exp, rv);
    endtask

    task automatic unlock_start(logic [7:0] c);
        wr(`NVAC_OFF_UNLOCK, 32'(`NVAC_KEY1));
        wr(`NVAC_OFF_UNLOCK, 32'(`NVAC_KEY2));
        wr(`NVAC_OFF_CTRL, 32'(c));
    endtask

    task automatic ee_wr(logic [7:0] a, logic [7:0] d, bit wait_done);
        wr(`NVAC_OFF_ADDR_LO, 32'(a));
        wr(`NVAC_OFF_DATA_LO, 32'(d));
        wr(`NVAC_OFF_CTRL, 32'h0000_0004);
        unlock_start(8'h06);
        if (wait_done) begin
            for (int i = 0; i < WC + 20 && write_done_flag !== 1'b1; i++) @(posedge hclk);
            chk("done flag", 32'h0000_0001, 32'(write_done_flag));
            chk("busy after write", 32'h0000_0000, 32'(write_busy));
            wr(`NVAC_OFF_STATUS, 32'h0000_0000);
            @(posedge hclk);
            chk("done cleared", 32'h0000_0000, 32'(write_done_flag));
        end
    endtask

    task automatic ee_rd(logic [7:0] a, logic [7:0] exp);
        wr(`NVAC_OFF_ADDR_LO, 32'(a));
        wr(`NVAC_OFF_CTRL, 32'h0000_0001);
        rdc("data byte", `NVAC_OFF_DATA_LO, 32'(exp));
        rdc("read start cleared", `NVAC_OFF_CTRL, 32'h0000_0000);
    endtask

    task automatic pm_rd(logic [11:0] a, logic [13:0] exp);
        wr(`NVAC_OFF_ADDR_HI, 32'(a[11:8]));
        wr(`NVAC_OFF_ADDR_LO, 32'(a[7:0]));
        wr(`NVAC_OFF_CTRL, 32'h0000_0081);
        rdc("word low", `NVAC_OFF_DATA_LO, 32'(exp[7:0]));
        rdc("word high", `NVAC_OFF_DATA_HI, 32'(exp[13:8]));
    endtask

    task automatic pgm(bit w, logic [11:0] a, logic [13:0] d);
        pgm_req <= 1'b1;
        pgm_write <= w;
        pgm_addr <= a;
        pgm_wdata <= d;
        @(posedge hclk);
        pgm_req <= 1'b0;
        @(posedge hclk);
        pw = pgm_rdata;
        pr = pgm_refused;
    endtask

    task automatic rst(bit por, bit ext, bit wdt);
        ext_ev <= ext;
        wdt_ev <= wdt;
        @(posedge hclk);
        ext_ev <= 1'b0;
        wdt_ev <= 1'b0;
        hresetn <= 1'b0;
        por_n <= !por;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge hclk);
    endtask

    initial begin
        {hresetn, por_n, ext_ev, wdt_ev, hsel, hwrite, code_protect, pgm_req, pgm_write} = 9'h000;
        {haddr, hwdata, htrans, hsize, pgm_addr, pgm_wdata} = '0;
        offs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge hclk);
        foreach (offs[i]) rdc("reset value", offs[i], 32'h0000_0000);
        wr(`NVAC_OFF_ADDR_HI, 32'hFFFF_FFFF);
        rdc("addr high", `NVAC_OFF_ADDR_HI, 32'h0000_000F);
        wr(`NVAC_OFF_DATA_HI, 32'hFFFF_FFFF);
        rdc("data high", `NVAC_OFF_DATA_HI, 32'h0000_003F);
        wr(`NVAC_OFF_UNLOCK, 32'h0000_00FF);
        rdc("unlock port", `NVAC_OFF_UNLOCK, 32'h0000_0000);
        wr(`NVAC_OFF_CTRL, 32'h0000_0004);
        wr(`NVAC_OFF_CTRL, 32'h0000_0006);
        repeat (3) @(posedge hclk);
        chk("start without keys", 32'h0000_0000, 32'(write_busy));
        wr(`NVAC_OFF_CTRL, 32'h0000_0000);
        unlock_start(8'h02);
        repeat (3) @(posedge hclk);
        chk("start without permit", 32'h0000_0000, 32'(write_busy));
        ee_wr(8'h00, 8'hA5, 1'b1);
        ee_wr(8'hFF, 8'h5A, 1'b1);
        ee_wr(8'hFF, 8'hC3, 1'b1);
        ee_rd(8'h00, 8'hA5);
        ee_rd(8'hFF, 8'hC3);
        pgm(1'b1, 12'hFFF, 14'h2A5C);
        pgm(1'b0, 12'hFFF, 14'h0000);
        chk("programmer word", 32'h0000_2A5C, 32'(pw));
        pm_rd(12'hFFF, 14'h2A5C);
        wr(`NVAC_OFF_CTRL, 32'h0000_0084);
        unlock_start(8'h86);
        repeat (3) @(posedge hclk);
        chk("program write", 32'h0000_0000, 32'(write_busy));
        wr(`NVAC_OFF_CTRL, 32'h0000_0000);
        code_protect <= 1'b1;
        pm_rd(12'hFFF, 14'h2A5C);
        ee_wr(8'h10, 8'h3C, 1'b1);
        ee_rd(8'h10, 8'h3C);
        pgm(1'b1, 12'hFFF, 14'h0000);
        chk("protected refusal", 32'h0000_0001, 32'(pr));
        code_protect <= 1'b0;
        pgm(1'b0, 12'hFFF, 14'h0000);
        chk("word kept", 32'h0000_2A5C, 32'(pw));
        for (int s = 0; s < 2; s++) begin
            ee_wr(8'h20 + 8'(s), 8'h77, 1'b0);
            rdc("write running", `NVAC_OFF_CTRL, 32'h0000_0006);
            rdc("timer busy", `NVAC_OFF_STATUS, 32'h0000_0002);
            repeat (5) @(posedge hclk);
            rst(1'b0, s == 0, s == 1);
            rdc("abort flag", `NVAC_OFF_CTRL, 32'h0000_000C);
            rdc("kept address", `NVAC_OFF_ADDR_LO, 32'h0000_0020 + 32'(s));
            rdc("kept data", `NVAC_OFF_DATA_LO, 32'h0000_0077);
            wr(`NVAC_OFF_CTRL, 32'h0000_0000);
        end
        rst(1'b1, 1'b0, 1'b0);
        rdc("power-up control", `NVAC_OFF_CTRL, 32'h0000_0000);
        rdc("power-up address", `NVAC_OFF_ADDR_LO, 32'h0000_0000);
        results;
    end
endmodule // nvac_top_tb
